// ===== rtl/pmz_pkg.sv
// Constants for the encoder zero-point front end.
// Assumes a single 125 MHz system clock and a 32-bit classic Wishbone bus.
package pmz_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned AUTOTUNE_S   = 7;
   localparam int unsigned AUTOTUNE_CYC = AUTOTUNE_S * CLK_HZ;
   localparam int unsigned MS_PER_S     = 1000;
   localparam int unsigned MS_CYC       = CLK_HZ / MS_PER_S;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] REG_CFG   = 8'h00;
   localparam logic [7:0] REG_TIME  = 8'h04;
   localparam logic [7:0] REG_TUNE  = 8'h08;
   localparam logic [7:0] REG_ANGLE = 8'h0c;
   localparam logic [7:0] REG_STAT  = 8'h10;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CFG_TYPE_LSB = 0;
   localparam int CFG_ABD_LSB  = 4;
   localparam int CFG_CONV_LSB = 8;
   localparam int CFG_ZPM_BIT  = 12;
   localparam int CFG_ZINV_BIT = 13;
   localparam int TIME_UW_LSB  = 0;
   localparam int TIME_UT_LSB  = 8;
   localparam int TIME_AW_LSB  = 16;
   localparam int TUNE_MODE_LSB = 0;
   localparam int TUNE_GO_BIT   = 8;
   localparam int TUNE_DCB_LSB  = 16;
   localparam int STAT_DONE_BIT = 1;
   // ****************************************
   // Encodings and reset values
   // ****************************************
   localparam logic [2:0] ENC_ABZ_UVW    = 3'h1;
   localparam logic [2:0] ENC_ABZ_SERIAL = 3'h2;
   localparam logic [2:0] ENC_ABZ_UVW_RW = 3'h3;
   localparam logic [2:0] ENC_SINE       = 3'h4;
   localparam logic [1:0] ABD_A_LEADS    = 2'h1;
   localparam logic [1:0] ABD_B_LEADS    = 2'h2;
   localparam logic [2:0] TUNE_PM_PHASE  = 3'h6;
   localparam logic [2:0] RST_TYPE       = 3'h1;
   localparam logic [1:0] RST_ABD        = 2'h1;
   localparam logic [7:0] RST_UVW_WAIT   = 8'h0a;
   localparam logic [7:0] RST_UVW_TIME   = 8'h0a;
   localparam logic [7:0] RST_ABZ_WAIT   = 8'h0a;
   localparam logic [6:0] RST_DC_BRAKE   = 7'h32;
   localparam logic [15:0] RST_ANGLE     = 16'h0000;
endpackage : pmz_pkg

// ===== rtl/pmz_front_end.sv
// Encoder front end: conditioning, direction, zero point, autotune, setup.
// Assumes encoder pins are asynchronous and a classic Wishbone master.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Encoder type 1..4 selects ABZ+UVW, ABZ+serial, reduced ABZ+UVW, sine.
// - Counterclockwise is forward; AB setting says which phase leads forward.
// - Mode 0, forward: A rising edge while Z high is the zero point.
// - Mode 0, reverse: A falling edge while Z high is the zero point.
// - Mode 1: Z rising edge is the zero point in both directions.
// - Z inversion set to 1 inverts Z before zero detection.
// - Autotune mode 6 overwrites the stored Z to winding angle; the code does so only if a zero pulse came during the run.
// - Reduced wiring honours UVW wait, UVW measure time and ABZ wait.
// - Autotune applies the DC brake current setting, default 50 percent.
// - Autotune mode 6 adjusts encoder phase and lasts about seven seconds.
// - ABZ conversion 0..15: bits invert A, B, Z; bit 3 swaps A and B.
module pmz_front_end
   import pmz_pkg::*;
#(
   parameter int unsigned TUNE_CYC = AUTOTUNE_CYC,
   parameter int unsigned TICK_CYC = MS_CYC
)(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Encoder pins
   input  wire logic        enc_a_i,
   input  wire logic        enc_b_i,
   input  wire logic        enc_z_i,
   input  wire logic [2:0]  enc_uvw_i,
   // Drive side
   output logic             zero_pulse_o,
   output logic             dir_fwd_o,
   output logic [2:0]       uvw_o,
   output logic             abz_ready_o,
   output logic             brake_on_o,
   output logic [6:0]       brake_level_o
);
   // ****************************************
   // Registers and bus
   // ****************************************
   logic [2:0]  enc_type_q;
   logic [1:0]  ab_dir_q;
   logic [3:0]  conv_q;
   logic        zp_mode_q, z_inv_q;
   logic [7:0]  uvw_wait_q, uvw_time_q, abz_wait_q;
   logic [2:0]  tune_mode_q;
   logic [6:0]  dc_brake_q;
   logic [15:0] angle_q, meas_q, pos_q;
   logic        meas_ok_q, busy_q, done_q, tune_end;
   logic        req, wr;
   logic [31:0] rd;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr  = req && wb_we_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req;
   end

   always_comb
   begin
      rd = 32'h0000_0000;
      unique case (wb_adr_i)
         REG_CFG:   rd = {18'h0, z_inv_q, zp_mode_q, conv_q, 2'h0,
                          ab_dir_q, 1'b0, enc_type_q};
         REG_TIME:  rd = {8'h00, abz_wait_q, uvw_time_q, uvw_wait_q};
         REG_TUNE:  rd = {9'h000, dc_brake_q, 13'h0000, tune_mode_q};
         REG_ANGLE: rd = {16'h0000, angle_q};
         REG_STAT:  rd = {pos_q, 9'h000, uvw_o, abz_ready_o, dir_fwd_o,
                          done_q, busy_q};
         default:   rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (req && !wb_we_i)
         wb_dat_o <= rd;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         enc_type_q <= RST_TYPE;
         ab_dir_q   <= RST_ABD;
         conv_q     <= 4'h0;
         zp_mode_q  <= 1'b0;
         z_inv_q    <= 1'b0;
      end
      else if (wr && wb_adr_i == REG_CFG)
      begin
         if (wb_sel_i[0])
            enc_type_q <= wb_dat_i[CFG_TYPE_LSB +: 3];
         if (wb_sel_i[0])
            ab_dir_q <= wb_dat_i[CFG_ABD_LSB +: 2];
         if (wb_sel_i[1])
         begin
            conv_q    <= wb_dat_i[CFG_CONV_LSB +: 4];
            zp_mode_q <= wb_dat_i[CFG_ZPM_BIT];
            z_inv_q   <= wb_dat_i[CFG_ZINV_BIT];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         uvw_wait_q <= RST_UVW_WAIT;
         uvw_time_q <= RST_UVW_TIME;
         abz_wait_q <= RST_ABZ_WAIT;
         tune_mode_q <= 3'h0;
         dc_brake_q  <= RST_DC_BRAKE;
      end
      else if (wr && wb_adr_i == REG_TIME)
      begin
         if (wb_sel_i[0]) uvw_wait_q <= wb_dat_i[TIME_UW_LSB +: 8];
         if (wb_sel_i[1]) uvw_time_q <= wb_dat_i[TIME_UT_LSB +: 8];
         if (wb_sel_i[2]) abz_wait_q <= wb_dat_i[TIME_AW_LSB +: 8];
      end
      else if (wr && wb_adr_i == REG_TUNE)
      begin
         if (wb_sel_i[0]) tune_mode_q <= wb_dat_i[TUNE_MODE_LSB +: 3];
         if (wb_sel_i[2]) dc_brake_q  <= wb_dat_i[TUNE_DCB_LSB +: 7];
      end
   end

   // ****************************************
   // Input synchronisers and conditioning
   // ****************************************
   logic [5:0] meta_q, sync_q;
   logic       a_c, b_c, z_c, a_p, b_p, z_p, step, dir_now;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_q <= 6'h00;
         sync_q <= 6'h00;
      end
      else
      begin
         meta_q <= {enc_uvw_i, enc_z_i, enc_b_i, enc_a_i};
         sync_q <= meta_q;
      end
   end

   // A/B swap and A, B, Z inversion, then the separate Z inversion
   assign a_c = conv_q[3] ? (sync_q[1] ^ conv_q[1])
                          : (sync_q[0] ^ conv_q[0]);
   assign b_c = conv_q[3] ? (sync_q[0] ^ conv_q[0])
                          : (sync_q[1] ^ conv_q[1]);
   assign z_c = sync_q[2] ^ conv_q[2] ^ z_inv_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         a_p <= 1'b0;
         b_p <= 1'b0;
         z_p <= 1'b0;
      end
      else
      begin
         a_p <= a_c;
         b_p <= b_c;
         z_p <= z_c;
      end
   end

   // Forward when A leads, unless the setting says B leads; the setting
   // of 2 is trusted to come with no extra conversion applied.
   assign step    = (a_c ^ a_p) ^ (b_c ^ b_p);
   assign dir_now = (a_c ^ b_p) ^ (ab_dir_q == ABD_B_LEADS);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dir_fwd_o <= 1'b1;
      else if (step)
         dir_fwd_o <= dir_now;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || (wr && wb_adr_i == REG_TUNE && wb_dat_i[TUNE_GO_BIT]))
         pos_q <= 16'h0000;
      else if (step)
         pos_q <= dir_now ? pos_q + 16'h0001 : pos_q - 16'h0001;
   end

   // ****************************************
   // Zero point detection
   // ****************************************
   logic zero_hit;
   always_comb
   begin
      if (zp_mode_q)
         zero_hit = z_c && !z_p;
      else
         zero_hit = z_c && (a_c ^ a_p) && step &&
                    (dir_now ? a_c : !a_c);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         zero_pulse_o <= 1'b0;
      else
         zero_pulse_o <= zero_hit && abz_ready_o;
   end

   // ****************************************
   // Reduced-wiring start-up sequence
   // ****************************************
   typedef enum logic [2:0] {RW_IDLE, RW_UVW_WAIT, RW_UVW_MEAS,
                             RW_ABZ_WAIT, RW_RUN} pmz_rw_t;
   pmz_rw_t     rw_q;
   logic [31:0] tick_cnt_q;
   logic        tick;
   logic [7:0]  ms_q;

   assign tick = (tick_cnt_q == TICK_CYC - 1);
   always_ff @(posedge clk_i)
   begin
      if (rst_i || tick)
         tick_cnt_q <= 32'h0000_0000;
      else
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || enc_type_q != ENC_ABZ_UVW_RW)
      begin
         rw_q <= RW_IDLE;
         ms_q <= 8'h00;
      end
      else
      begin
         unique case (rw_q)
            RW_IDLE:
            begin
               rw_q <= RW_UVW_WAIT;
               ms_q <= 8'h00;
            end
            RW_UVW_WAIT, RW_UVW_MEAS, RW_ABZ_WAIT:
            begin
               if (ms_q >= (rw_q == RW_UVW_WAIT ? uvw_wait_q :
                            rw_q == RW_UVW_MEAS ? uvw_time_q :
                            abz_wait_q))
               begin
                  rw_q <= (rw_q == RW_UVW_WAIT) ? RW_UVW_MEAS :
                          (rw_q == RW_UVW_MEAS) ? RW_ABZ_WAIT : RW_RUN;
                  ms_q <= 8'h00;
               end
               else if (tick)
                  ms_q <= ms_q + 8'h01;
            end
            RW_RUN: rw_q <= RW_RUN;
         endcase
      end
   end

   // UVW from own pins, or from the shared wires during measurement
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         uvw_o       <= 3'h0;
         abz_ready_o <= 1'b0;
      end
      else
      begin
         if (enc_type_q == ENC_ABZ_UVW)
            uvw_o <= sync_q[5:3];
         else if (rw_q == RW_UVW_MEAS)
            uvw_o <= sync_q[2:0];
         abz_ready_o <= (enc_type_q != ENC_ABZ_UVW_RW) ||
                        (rw_q == RW_RUN);
      end
   end

   // ****************************************
   // Autotune, encoder phase adjustment
   // ****************************************
   logic [31:0] tune_cnt_q;
   logic        go;

   assign go = wr && wb_adr_i == REG_TUNE && wb_sel_i[1] &&
               wb_dat_i[TUNE_GO_BIT] &&
               wb_dat_i[TUNE_MODE_LSB +: 3] == TUNE_PM_PHASE;
   assign tune_end = busy_q && (tune_cnt_q == TUNE_CYC - 1);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_q     <= 1'b0;
         tune_cnt_q <= 32'h0000_0000;
      end
      else if (go && !busy_q)
      begin
         busy_q     <= 1'b1;
         tune_cnt_q <= 32'h0000_0000;
      end
      else if (busy_q)
      begin
         busy_q     <= !tune_end;
         tune_cnt_q <= tune_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || (go && !busy_q))
      begin
         meas_q    <= 16'h0000;
         meas_ok_q <= 1'b0;
      end
      else if (busy_q && zero_pulse_o && !meas_ok_q)
      begin
         meas_q    <= pos_q;
         meas_ok_q <= 1'b1;
      end
   end

   // Hardware result wins over a software write in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         angle_q <= RST_ANGLE;
      else if (tune_end && meas_ok_q)
         angle_q <= meas_q;
      else if (wr && wb_adr_i == REG_ANGLE && wb_sel_i[0] && wb_sel_i[1])
         angle_q <= wb_dat_i[15:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         done_q <= 1'b0;
      else if (tune_end)
         done_q <= 1'b1;
      else if (wr && wb_adr_i == REG_STAT && wb_dat_i[STAT_DONE_BIT])
         done_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         brake_on_o    <= 1'b0;
         brake_level_o <= 7'h00;
      end
      else
      begin
         brake_on_o    <= busy_q;
         brake_level_o <= busy_q ? dc_brake_q : 7'h00;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   zero_width_a: assert property (zero_pulse_o |=> !zero_pulse_o)
      else $error("zero pulse wider than one cycle");
   zero_zmode_a: assert property (zero_pulse_o && zp_mode_q &&
         $stable(zp_mode_q) |-> $past(z_c) && !$past(z_p))
      else $error("zero pulse without Z rise");
   zero_fwd_a: assert property (zero_pulse_o && !zp_mode_q &&
         $stable(zp_mode_q) |-> $past(z_c) &&
         ($past(a_c) == $past(dir_now)))
      else $error("zero pulse on wrong A edge");
   zero_gate_a: assert property (!abz_ready_o |=> !zero_pulse_o)
      else $error("zero pulse before ABZ ready");
   brake_busy_a: assert property (busy_q |=> brake_on_o &&
         brake_level_o == $past(dc_brake_q))
      else $error("brake not applied during tuning");
   tune_go_a: assert property (go && !busy_q |=> busy_q)
      else $error("mode 6 start did not run");
   tune_len_a: assert property ($fell(busy_q) |->
         $past(tune_cnt_q) == TUNE_CYC - 1)
      else $error("tuning ended at wrong count");
   angle_upd_a: assert property (tune_end && meas_ok_q |=>
         angle_q == $past(meas_q))
      else $error("angle not stored");
   done_set_a: assert property (tune_end |=> done_q)
      else $error("done flag lost");
   rw_ready_a: assert property (enc_type_q == ENC_ABZ_UVW_RW &&
         rw_q != RW_RUN |=> !abz_ready_o)
      else $error("ABZ ready during start-up");

   zero_seen_c: cover property (zero_pulse_o);
   tune_done_c: cover property (tune_end && meas_ok_q);
   rw_run_c:    cover property (rw_q == RW_RUN);
   rev_zero_c:  cover property (zero_pulse_o && !dir_fwd_o);
endmodule : pmz_front_end

`default_nettype wire

// ===== tb/pmz_enc_model.sv
// Shaft encoder model: quadrature A/B and an index line Z.
// Assumes step and toggle requests arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module pmz_enc_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Requests
   input  wire logic step_i,
   input  wire logic fwd_i,
   input  wire logic ztog_i,
   // Encoder pins
   output logic      a_o,
   output logic      b_o,
   output logic      z_o
);
   // ****************************************
   // Shaft position
   // ****************************************
   logic [1:0] ph_q;
   logic       z_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ph_q <= 2'h0;
      else if (step_i)
         ph_q <= fwd_i ? ph_q + 2'h1 : ph_q - 2'h1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         z_q <= 1'b0;
      else if (ztog_i)
         z_q <= ~z_q;
   end
   // A leads B while turning counterclockwise
   assign a_o = ph_q[1] ^ ph_q[0];
   assign b_o = ph_q[1];
   assign z_o = z_q;
endmodule : pmz_enc_model
`default_nettype wire

// ===== tb/pm_encoder_zero_point_front_end_tb_top.sv
// Random and corner tests of the encoder front end.
// Assumes the encoder model and the front end with short counts.
`timescale 1ns/1ps
`default_nettype none
module pm_encoder_zero_point_front_end_tb_top
   import pmz_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd, rdo;
   logic [2:0]  uvw = 3'h0, uvo;
   logic        step = 1'b0, fwd = 1'b0, ztog = 1'b0;
   logic        a, b, z, zp, dfw, ardy, bon, ack;
   logic [6:0]  blev;
   logic [31:0] seed = 32'h79367b43;
   int          bad_count = 0, tests_run = 0, zc = 0, cyc_n = 0, n;
   logic [1:0]  abd = 2'h1;
   logic [3:0]  conv = 4'h0;
   logic        zpm = 1'b0, zinv = 1'b0;
   pmz_front_end #(.TUNE_CYC(200), .TICK_CYC(4)) i_pmz_front_end (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdo), .wb_ack_o(ack), .enc_a_i(a), .enc_b_i(b),
      .enc_z_i(z), .enc_uvw_i(uvw), .zero_pulse_o(zp), .dir_fwd_o(dfw),
      .uvw_o(uvo), .abz_ready_o(ardy), .brake_on_o(bon),
      .brake_level_o(blev));
   pmz_enc_model i_pmz_enc_model (.clk_i(clk_i), .rst_i(rst_i),
      .step_i(step), .fwd_i(fwd), .ztog_i(ztog), .a_o(a), .b_o(b),
      .z_o(z));
   initial
   begin
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      if (zp === 1'b1)
         zc <= zc + 1;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end
   // ****************************************
   // Expectations
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [2:0] cond(input logic [2:0] p);
      logic [2:0] c;
      c = p ^ {conv[0], conv[1], conv[2] ^ zinv};
      return conv[3] ? {c[1], c[2], c[0]} : c;
   endfunction : cond
   function automatic logic dexp(input logic [2:0] o, input logic [2:0] n);
      logic [2:0] x;
      logic [2:0] y;
      x = cond(o);
      y = cond(n);
      return y[2] ^ x[1] ^ (abd == 2'h2);
   endfunction : dexp
   function automatic logic zexp(input logic [2:0] o, input logic [2:0] n);
      logic [2:0] x;
      logic [2:0] y;
      x = cond(o);
      y = cond(n);
      if (zpm)
         return !x[0] && y[0];
      return x[2] != y[2] && y[0] && y[2] == dexp(o, n);
   endfunction : zexp
   // ****************************************
   // Bus, encoder and check tasks
   // ****************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'b1);
      chk("wb_ack_wait", k, 32'h2);
      rd = rdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic setcfg(input logic [2:0] t);
      wb(1'b1, REG_CFG, {18'h0, zinv, zpm, conv, 2'h0, abd, 1'b0, t});
      repeat (8) @(posedge clk_i);
   endtask : setcfg
   task automatic act(input int k);
      logic [2:0] o;
      int         z0;
      o = {a, b, z};
      z0 = zc;
      @(posedge clk_i);
      step <= (k < 2);
      fwd <= (k == 0);
      ztog <= (k == 2);
      @(posedge clk_i);
      step <= 1'b0;
      ztog <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("zeros", zc - z0, zexp(o, {a, b, z}));
      if (k < 2)
         chk("dir_fwd", dfw, dexp(o, {a, b, z}));
   endtask : act
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("dir_rst", dfw, 32'h1);
      wb(1'b0, REG_CFG, 32'h0);
      chk("cfg_rst", rd, 32'h11);
      wb(1'b0, REG_TIME, 32'h0);
      chk("time_rst", rd, 32'h000a0a0a);
      wb(1'b0, REG_TUNE, 32'h0);
      chk("brake_rst", rd[22:16], 7'h32);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (int i = 0; i < 48; i++)
      begin
         seed = xs(seed);
         abd = (i < 16 || seed[0]) ? 2'h1 : 2'h2;
         conv = (i < 16) ? 4'(i) : (abd == 2'h2 ? 4'h0 : seed[7:4]);
         zpm = seed[8];
         zinv = seed[9];
         uvw <= seed[12:10];
         setcfg(ENC_ABZ_UVW);
         chk("uvw", uvo, seed[12:10]);
         for (int j = 0; j < 6; j++)
         begin
            seed = xs(seed);
            act(int'(seed % 3));
         end
      end
      wb(1'b1, REG_TIME, 32'h00010102);
      wb(1'b1, REG_CFG,
         {18'h0, zinv, zpm, conv, 2'h0, abd, 1'b0, ENC_ABZ_UVW_RW});
      repeat (2) @(posedge clk_i);
      chk("ready_low", ardy, 32'h0);
      n = 0;
      while (ardy !== 1'b1 && n < 60)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("ready_high", ardy, 32'h1);
      chk("uvw_rw", uvo, {z, b, a});
      abd = 2'h1;
      conv = 4'h0;
      zinv = 1'b0;
      zpm = 1'b1;
      setcfg(ENC_ABZ_UVW);
      if (z)
         act(2);
      wb(1'b1, REG_TUNE, 32'h00320105);
      wb(1'b0, REG_STAT, 32'h0);
      chk("busy_other_mode", rd[0], 32'h0);
      wb(1'b1, REG_TUNE, 32'h00320106);
      repeat (3) @(posedge clk_i);
      chk("brake_on", bon, 32'h1);
      chk("brake_level", blev, 7'h32);
      repeat (5) act(0);
      act(2);
      wb(1'b0, REG_STAT, 32'h0);
      chk("busy", rd[0], 32'h1);
      n = 0;
      do
      begin
         wb(1'b0, REG_STAT, 32'h0);
         n++;
      end
      while (rd[1] !== 1'b1 && n < 120);
      chk("done", rd[1:0], 2'h2);
      chk("brake_off", {bon, blev}, 8'h0);
      wb(1'b0, REG_ANGLE, 32'h0);
      chk("angle", rd[15:0], 16'h0005);
      wb(1'b1, REG_STAT, 32'h2);
      wb(1'b0, REG_STAT, 32'h0);
      chk("done_clear", rd[1], 32'h0);
      stop_test();
   end
endmodule : pm_encoder_zero_point_front_end_tb_top
`default_nettype wire
